// ===== ptrp_pkg.sv
// Shared constants and types for the paper tape reader and punch control
package ptrp_pkg;

  // ==========================================================================
  // Widths
  localparam int WORD_W  = 48;  // Host word width
  localparam int CHAR_W  = 6;   // Assembly mode character
  localparam int FRAME_W = 8;   // Tape frame, levels 1 to 8
  localparam int EXF_W   = 15;  // Five octal digits
  localparam int ADDR_W  = 15;  // Storage address
  localparam int INSN_W  = 24;  // Half word instruction
  localparam int CNT_W   = 3;   // Assembly and disassembly counters

  // ==========================================================================
  // Field positions and counts
  localparam int            LVL7_POS  = 6;     // Control level in a frame
  localparam logic [CNT_W-1:0] CNT_FIRST = 3'h0;  // Character 0
  localparam logic [CNT_W-1:0] CNT_LAST  = 3'h7;  // Eighth character

  // ==========================================================================
  // External function codes, upper four octal digits (low digit ignored)
  localparam logic [11:0] EXF_RD_INT_EOT = 12'h250;  // 1120X
  localparam logic [11:0] EXF_RD_SET_EOT = 12'h251;  // 1121X
  localparam logic [11:0] EXF_RD_NO_INT  = 12'h252;  // 1122X
  localparam logic [11:0] EXF_PU_ASSY    = 12'h450;  // 2120X
  localparam logic [11:0] EXF_PU_CHAR    = 12'h451;  // 2121X
  localparam logic [11:0] EXF_PU_MOTOFF  = 12'h454;  // 2124X

  // ==========================================================================
  // Bootstrap image
  localparam logic [ADDR_W-1:0] BOOT_ADDR0 = 15'h0010;  // 00020 octal
  localparam logic [ADDR_W-1:0] BOOT_ADDR1 = 15'h0011;  // 00021 octal
  localparam logic [INSN_W-1:0] BOOT_I0    = 24'hF08012;  // Activate reader into 00022
  localparam logic [INSN_W-1:0] BOOT_I1    = 24'hF39280;  // Wait for end of tape
  localparam logic [INSN_W-1:0] BOOT_I2    = 24'hF08000;  // Deactivate buffer

  // ==========================================================================
  // Auto load sequencer states, Gray along the path
  typedef enum logic [1:0] {
    PTRP_B_IDLE = 2'h0,
    PTRP_B_W0   = 2'h1,
    PTRP_B_W1   = 2'h3,
    PTRP_B_GO   = 2'h2
  } ptrp_boot_t;

endpackage : ptrp_pkg

// ===== ptrp_if.sv
// Buffer channel link between host computer and tape control
`timescale 1ns/10ps
`default_nettype none
interface ptrp_if;
  import ptrp_pkg::*;

  // ==========================================================================
  // Input channel (reader to host)
  logic [WORD_W-1:0] in_word;
  logic              in_ready;
  logic              in_resume;
  logic              in_active;
  // Output channel (host to punch)
  logic [WORD_W-1:0] out_word;
  logic              out_ready;
  logic              out_resume;
  logic              out_active;
  // External function strobe
  logic              exf_valid;
  logic [EXF_W-1:0]  exf_code;

  modport dev (
    output in_word, in_ready, out_resume,
    input  in_resume, in_active, out_word, out_ready, out_active, exf_valid, exf_code
  );
  modport host (
    input  in_word, in_ready, out_resume,
    output in_resume, in_active, out_word, out_ready, out_active, exf_valid, exf_code
  );
endinterface : ptrp_if
`default_nettype wire

// ===== ptrp_dev.sv
// Tape reader and punch control, device end of the buffer channels
`timescale 1ns/10ps
`default_nettype none
module ptrp_dev #(
  parameter logic [ptrp_pkg::INSN_W-1:0] PASS_INSN = 24'h000000  // Filler half word
) (
  // Clock and reset
  input  wire logic                          sys_clk_in,
  input  wire logic                          sys_rst_in,
  // Host link
  ptrp_if.dev                                lnk,
  // Reader pins
  input  wire logic [ptrp_pkg::FRAME_W-1:0]  tape_frame_in,
  input  wire logic                          feed_hole_in,
  input  wire logic                          mode_assy_sw_in,
  input  wire logic                          mode_char_sw_in,
  output logic                               reader_clutch_out,
  output logic                               end_of_tape_out,
  output logic                               reader_char_mode_out,
  // Punch pins
  input  wire logic                          punch_timing_in,
  input  wire logic                          punch_leader_key_in,
  input  wire logic                          out_of_tape_in,
  output logic [ptrp_pkg::FRAME_W-1:0]       punch_magnets_out,
  output logic                               feed_magnet_out,
  output logic                               punch_motor_out,
  output logic                               out_of_tape_out,
  // Auto load
  input  wire logic                          auto_load_sw_in,
  input  wire logic [ptrp_pkg::ADDR_W-1:0]   breakpoint_addr_in,
  output logic                               boot_we_out,
  output logic [ptrp_pkg::ADDR_W-1:0]        boot_addr_out,
  output logic [ptrp_pkg::WORD_W-1:0]        boot_data_out,
  output logic                               boot_start_out
);
  import ptrp_pkg::*;

  // ==========================================================================
  // State
  typedef struct packed {
    // Synchronisers, stage 1 read only by stage 2
    logic [FRAME_W-1:0] frame_s1;
    logic [FRAME_W-1:0] frame_s2;
    logic [ADDR_W-1:0]  bp_s1;
    logic [ADDR_W-1:0]  bp_s2;
    logic [2:0]         feed_s;
    logic [2:0]         tim_s;
    logic [2:0]         asw_s;
    logic [2:0]         csw_s;
    logic [2:0]         boot_s;
    logic [1:0]         key_s;
    logic [1:0]         oot_s;
    // Reader
    logic               in_active_d;
    logic               reader_sel;
    logic               char_mode;
    logic               load_point;
    logic               clutch;
    logic               end_of_tape_flag;
    logic [CNT_W-1:0]   asm_cnt;
    logic [WORD_W-1:0]  input_assembly_register;
    logic               in_ready;
    // Punch
    logic               punch_sel;
    logic               punch_char;
    logic               motor;
    logic [CNT_W-1:0]   dis_cnt;
    logic               p_ready;
    logic               punch_resume_flop;
    logic [FRAME_W-1:0] punch_reg;
    logic               first_feed_flop;
    logic               second_feed_flop;
    // Auto load
    ptrp_boot_t         bstate;
    logic               bwe;
    logic [ADDR_W-1:0]  baddr;
    logic [WORD_W-1:0]  bdata;
    logic               bstart;
  } ptrp_dev_st_t;

  ptrp_dev_st_t st_r;
  ptrp_dev_st_t st_nxt;

  // ==========================================================================
  // Next state
  always_comb begin
    logic              feed_ev;
    logic              tim_ev;
    logic              asw_ev;
    logic              csw_ev;
    logic              boot_ev;
    logic              key_dn;
    logic [11:0]       exf_hi;
    logic [CHAR_W-1:0] pchar;
    logic [FRAME_W-1:0] frame;
    feed_ev = st_r.feed_s[1] & ~st_r.feed_s[2];
    tim_ev  = st_r.tim_s[1] & ~st_r.tim_s[2];
    asw_ev  = st_r.asw_s[1] & ~st_r.asw_s[2];
    csw_ev  = st_r.csw_s[1] & ~st_r.csw_s[2];
    boot_ev = st_r.boot_s[1] & ~st_r.boot_s[2];
    key_dn  = st_r.key_s[1];
    frame   = st_r.frame_s2;
    exf_hi  = lnk.exf_code[EXF_W-1:3];
    pchar   = '0;
    st_nxt  = st_r;

    // Pin synchronisers and edge history
    st_nxt.frame_s1 = tape_frame_in;
    st_nxt.frame_s2 = st_r.frame_s1;
    st_nxt.bp_s1    = breakpoint_addr_in;
    st_nxt.bp_s2    = st_r.bp_s1;
    st_nxt.feed_s   = {st_r.feed_s[1:0], feed_hole_in};
    st_nxt.tim_s    = {st_r.tim_s[1:0], punch_timing_in};
    st_nxt.asw_s    = {st_r.asw_s[1:0], mode_assy_sw_in};
    st_nxt.csw_s    = {st_r.csw_s[1:0], mode_char_sw_in};
    st_nxt.boot_s   = {st_r.boot_s[1:0], auto_load_sw_in};
    st_nxt.key_s    = {st_r.key_s[0], punch_leader_key_in};
    st_nxt.oot_s    = {st_r.oot_s[0], out_of_tape_in};
    st_nxt.in_active_d = lnk.in_active;

    // Reader mode switches
    if (asw_ev) begin
      st_nxt.load_point       = 1'b1;
      st_nxt.char_mode        = 1'b0;
      st_nxt.clutch           = 1'b1;
      st_nxt.end_of_tape_flag = 1'b0;
    end
    if (csw_ev) begin
      st_nxt.char_mode        = 1'b1;
      st_nxt.asm_cnt          = CNT_FIRST;
      st_nxt.clutch           = 1'b1;
      st_nxt.end_of_tape_flag = 1'b0;
    end

    // Function codes; the end of tape set comes after any clear so it wins
    if (lnk.exf_valid) begin
      case (exf_hi)
        EXF_RD_INT_EOT, EXF_RD_NO_INT: begin
          st_nxt.reader_sel       = 1'b1;
          st_nxt.end_of_tape_flag = 1'b0;
        end
        EXF_RD_SET_EOT: begin
          st_nxt.reader_sel       = 1'b1;
          st_nxt.end_of_tape_flag = 1'b1;
        end
        EXF_PU_ASSY: begin
          st_nxt.punch_sel  = 1'b1;
          st_nxt.punch_char = 1'b0;
          st_nxt.motor      = 1'b1;
        end
        EXF_PU_CHAR: begin
          st_nxt.punch_sel  = 1'b1;
          st_nxt.punch_char = 1'b1;
          st_nxt.motor      = 1'b1;
        end
        EXF_PU_MOTOFF: begin
          st_nxt.motor = 1'b0;
        end
        default: begin
        end
      endcase
    end

    // Reader: idle buffer holds clears; the frame move after a char step ends the pulse
    if (!lnk.in_active) begin
      st_nxt.input_assembly_register = '0;
      st_nxt.in_ready                = 1'b0;
      if (!st_r.char_mode) begin
        st_nxt.asm_cnt = CNT_FIRST;
      end
      if ((st_r.in_active_d || feed_ev) && !st_r.load_point && !asw_ev && !csw_ev) begin
        st_nxt.clutch = 1'b0;
      end
    end
    if (st_r.load_point && feed_ev && frame[LVL7_POS]) begin
      st_nxt.load_point = 1'b0;
      st_nxt.clutch     = 1'b0;
    end else if (lnk.in_active && !st_r.load_point) begin
      // Halted assembly stays stopped until a new mode selection or a 1120X/1122X function code clears end of tape
      st_nxt.clutch = ~st_r.end_of_tape_flag | st_r.char_mode;
      if (lnk.in_resume) begin
        st_nxt.input_assembly_register = '0;
        st_nxt.in_ready                = 1'b0;
      end
      if (feed_ev && st_r.clutch) begin
        if (st_r.char_mode) begin
          st_nxt.input_assembly_register = {{(WORD_W-FRAME_W){1'b0}}, frame};
          st_nxt.in_ready                = 1'b1;
        end else if (st_r.asm_cnt == CNT_FIRST && !frame[LVL7_POS]) begin
          st_nxt.end_of_tape_flag = 1'b1;
          st_nxt.clutch           = 1'b0;
        end else begin
          for (int i = 0; i < 8; i++) begin
            if (st_r.asm_cnt == CNT_W'(i)) begin
              st_nxt.input_assembly_register[WORD_W-1-CHAR_W*i -: CHAR_W] = frame[CHAR_W-1:0];
            end
          end
          st_nxt.asm_cnt = st_r.asm_cnt + 3'h1;
          if (st_r.asm_cnt == CNT_LAST) begin
            st_nxt.in_ready = 1'b1;
          end
        end
      end
    end
    if (!st_r.reader_sel) begin
      st_nxt.input_assembly_register = '0;
    end

    // Punch: counter held at its start while out_active is low
    if (st_r.punch_char) begin
      st_nxt.dis_cnt = CNT_FIRST;
    end else if (!lnk.out_active) begin
      st_nxt.dis_cnt = CNT_LAST;
    end
    if (!lnk.out_ready) begin
      st_nxt.punch_resume_flop = 1'b0;
    end
    if (st_r.punch_sel && st_r.motor && lnk.out_active && lnk.out_ready && !key_dn &&
        !st_r.punch_resume_flop && !st_r.tim_s[1]) begin
      st_nxt.p_ready = 1'b1;
    end
    for (int i = 0; i < 8; i++) begin
      if (st_r.dis_cnt == CNT_W'(i)) begin
        pchar = lnk.out_word[CHAR_W*i +: CHAR_W];
      end
    end
    st_nxt.second_feed_flop = st_r.first_feed_flop;
    if (tim_ev) begin
      st_nxt.punch_reg       = '0;
      st_nxt.first_feed_flop = 1'b0;
      if (st_r.p_ready) begin
        st_nxt.punch_reg       = st_r.punch_char ? lnk.out_word[FRAME_W-1:0]
                                                 : {2'b00, pchar};
        st_nxt.first_feed_flop = 1'b1;
        st_nxt.p_ready         = 1'b0;
        if (st_r.dis_cnt == CNT_FIRST) begin
          st_nxt.punch_resume_flop = 1'b1;
        end
        if (!st_r.punch_char) begin
          st_nxt.dis_cnt = st_r.dis_cnt - 3'h1;
        end
      end
    end
    if (key_dn) begin
      st_nxt.first_feed_flop  = 1'b1;
      st_nxt.second_feed_flop = 1'b1;
    end

    // Auto load sequencer
    case (st_r.bstate)
      PTRP_B_IDLE: begin
        st_nxt.bstart = 1'b0;
        if (boot_ev) begin
          st_nxt.bstate = PTRP_B_W0;
          st_nxt.bwe    = 1'b1;
          st_nxt.baddr  = BOOT_ADDR0;
          st_nxt.bdata  = {BOOT_I0, BOOT_I1};
        end
      end
      PTRP_B_W0: begin
        st_nxt.bstate = PTRP_B_W1;
        st_nxt.baddr  = BOOT_ADDR1;
        st_nxt.bdata  = {BOOT_I2, PASS_INSN};
      end
      PTRP_B_W1: begin
        st_nxt.bstate = PTRP_B_GO;
        st_nxt.bwe    = 1'b0;
        // A breakpoint on the bootstrap itself leaves it loaded but not run
        st_nxt.bstart = (st_r.bp_s2 != BOOT_ADDR0) && (st_r.bp_s2 != BOOT_ADDR1);
      end
      PTRP_B_GO: begin
        st_nxt.bstate = PTRP_B_IDLE;
        st_nxt.bstart = 1'b0;
      end
      default: begin
        st_nxt.bstate = PTRP_B_IDLE;
      end
    endcase
  end

  // ==========================================================================
  // State register
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================================
  // Outputs, all straight from flops
  assign lnk.in_word           = st_r.input_assembly_register;
  assign lnk.in_ready          = st_r.in_ready;
  assign lnk.out_resume        = st_r.punch_resume_flop;
  assign reader_clutch_out     = st_r.clutch;
  assign end_of_tape_out       = st_r.end_of_tape_flag;
  assign reader_char_mode_out  = st_r.char_mode;
  assign punch_magnets_out     = st_r.punch_reg;
  assign feed_magnet_out       = st_r.second_feed_flop;
  assign punch_motor_out       = st_r.motor;
  assign out_of_tape_out       = st_r.oot_s[1];
  assign boot_we_out           = st_r.bwe;
  assign boot_addr_out         = st_r.baddr;
  assign boot_data_out         = st_r.bdata;
  assign boot_start_out        = st_r.bstart;

endmodule : ptrp_dev
`default_nettype wire

// ===== ptrp_host.sv
// Tape control link, host computer end of the buffer channels
`timescale 1ns/10ps
`default_nettype none
module ptrp_host (
  // Clock and reset
  input  wire logic                         sys_clk_in,
  input  wire logic                         sys_rst_in,
  // Link to the tape control
  ptrp_if.host                              lnk,
  // Function code request
  input  wire logic                         exf_req_in,
  input  wire logic [ptrp_pkg::EXF_W-1:0]   exf_code_in,
  // Reader side
  input  wire logic                         rd_enable_in,
  output logic [ptrp_pkg::WORD_W-1:0]       rd_word_out,
  output logic                              rd_valid_out,
  // Punch side
  input  wire logic                         pw_enable_in,
  input  wire logic                         pw_valid_in,
  input  wire logic [ptrp_pkg::WORD_W-1:0]  pw_word_in,
  output logic                              pw_ready_out
);
  import ptrp_pkg::*;

  // ==========================================================================
  // State
  typedef struct packed {
    logic              exf_valid;
    logic [EXF_W-1:0]  exf_code;
    logic              in_active;
    logic              in_resume;
    logic [WORD_W-1:0] rd_word;
    logic              rd_valid;
    logic              out_active;
    logic              out_ready;
    logic [WORD_W-1:0] out_word;
    logic              pw_ready;
  } ptrp_host_st_t;

  ptrp_host_st_t st_r;
  ptrp_host_st_t st_nxt;

  // ==========================================================================
  // Next state
  always_comb begin
    logic take;
    take   = pw_valid_in & st_r.pw_ready;
    st_nxt = st_r;
    st_nxt.exf_valid  = exf_req_in;
    st_nxt.exf_code   = exf_req_in ? exf_code_in : st_r.exf_code;
    st_nxt.in_active  = rd_enable_in;
    st_nxt.out_active = pw_enable_in;

    // Reader: one resume per ready; the device drops ready one edge later
    st_nxt.rd_valid  = 1'b0;
    st_nxt.in_resume = 1'b0;
    if (lnk.in_ready && st_r.in_active && !st_r.in_resume) begin
      st_nxt.rd_word   = lnk.in_word;
      st_nxt.rd_valid  = 1'b1;
      st_nxt.in_resume = 1'b1;
    end

    // Punch: drop ready on resume, then load the next word
    if (lnk.out_resume && st_r.out_ready) begin
      st_nxt.out_ready = 1'b0;
    end
    if (take) begin
      st_nxt.out_word  = pw_word_in;
      st_nxt.out_ready = 1'b1;
    end
    if (!pw_enable_in) begin
      st_nxt.out_ready = 1'b0;
    end
    // Slot opens only once the old resume has cleared
    st_nxt.pw_ready = pw_enable_in & ~st_nxt.out_ready & ~lnk.out_resume & ~take;
  end

  // ==========================================================================
  // State register
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================================
  // Outputs
  assign lnk.exf_valid  = st_r.exf_valid;
  assign lnk.exf_code   = st_r.exf_code;
  assign lnk.in_active  = st_r.in_active;
  assign lnk.in_resume  = st_r.in_resume;
  assign lnk.out_active = st_r.out_active;
  assign lnk.out_ready  = st_r.out_ready;
  assign lnk.out_word   = st_r.out_word;
  assign rd_word_out    = st_r.rd_word;
  assign rd_valid_out   = st_r.rd_valid;
  assign pw_ready_out   = st_r.pw_ready;

endmodule : ptrp_host
`default_nettype wire

// ===== ptrp_properties.sv
// Link checker for the tape control buffer channels
`timescale 1ns/10ps
`default_nettype none
module ptrp_properties
  import ptrp_pkg::*;
(
  // Clock and reset
  input wire logic              sys_clk_in,
  input wire logic              sys_rst_in,
  // Link signals
  input wire logic [WORD_W-1:0] in_word,
  input wire logic              in_ready,
  input wire logic              in_resume,
  input wire logic              in_active,
  input wire logic              out_ready,
  input wire logic              out_resume,
  input wire logic              out_active
);
  // ==========================================================================
  // One clock domain, so one default
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (sys_rst_in);

  // Word handed over, host answers
  sequence s_in_taken;
    in_ready && in_resume;
  endsequence
  // Word waiting, nothing clears it yet
  sequence s_in_wait;
    in_ready && !in_resume && in_active;
  endsequence
  // Punch word done while host still holds ready
  sequence s_out_done;
    out_resume && out_ready;
  endsequence

  chk_resume_drops_ready: assert property (s_in_taken |=> !in_ready)
    else $error("reader ready stayed after resume");
  chk_resume_clears_word: assert property (s_in_taken |=> in_word == '0)
    else $error("assembly word kept after resume");
  chk_word_holds: assert property (s_in_wait |=> $stable(in_word))
    else $error("assembly word moved while waiting");
  chk_ready_holds: assert property (s_in_wait |=> in_ready)
    else $error("reader ready dropped without resume");
  chk_ready_needs_active: assert property ($rose(in_ready) |-> in_active)
    else $error("reader ready without buffer active");
  chk_punch_resume_cause: assert property ($rose(out_resume) |-> out_ready && out_active)
    else $error("punch resume without loaded word");
  chk_punch_resume_drop: assert property (!out_ready |=> !out_resume)
    else $error("punch resume stayed after ready dropped");
  chk_punch_resume_hold: assert property (s_out_done |=> out_resume)
    else $error("punch resume vanished while ready high");
endmodule : ptrp_properties
`default_nettype wire

// ===== paper_tape_reader_punch_control_bench.sv
// Self-checking bench joining host and tape control ends
`timescale 1ns/10ps
`default_nettype none
module paper_tape_reader_punch_control_bench;
  import ptrp_pkg::*;
  // ==========================================================================
  // Stimulus and observation
  logic sys_clk = 0, sys_rst = 1, exf_req = 0, rd_en = 0, pw_en = 0, pw_valid = 0, feed = 0;
  logic m_assy = 0, m_char = 0, ptim = 0, lead = 0, oot = 0, al_sw = 0;
  logic [14:0] exf_code = '0, bp = '0, ba [4], baddr;
  logic [47:0] pw_word = '0, rd_word, lastw, bd [4], bdata;
  logic [7:0]  frame = '0, mag;
  logic        rd_valid, pw_ready, clutch, eot, cmode, fmag, motor, ootout, bwe, bstart;
  int          errors = 0, checked = 0, nval = 0, nb = 0, nst = 0, cyc_cnt = 0;

  ptrp_if lnk ();
  ptrp_dev ptrp_dev_inst (.sys_clk_in(sys_clk), .sys_rst_in(sys_rst), .lnk(lnk), .tape_frame_in(frame),
    .feed_hole_in(feed), .mode_assy_sw_in(m_assy), .mode_char_sw_in(m_char), .reader_clutch_out(clutch),
    .end_of_tape_out(eot), .reader_char_mode_out(cmode), .punch_timing_in(ptim), .punch_leader_key_in(lead),
    .out_of_tape_in(oot), .punch_magnets_out(mag), .feed_magnet_out(fmag), .punch_motor_out(motor),
    .out_of_tape_out(ootout), .auto_load_sw_in(al_sw), .breakpoint_addr_in(bp), .boot_we_out(bwe),
    .boot_addr_out(baddr), .boot_data_out(bdata), .boot_start_out(bstart));
  ptrp_host ptrp_host_inst (.sys_clk_in(sys_clk), .sys_rst_in(sys_rst), .lnk(lnk), .exf_req_in(exf_req),
    .exf_code_in(exf_code), .rd_enable_in(rd_en), .rd_word_out(rd_word), .rd_valid_out(rd_valid),
    .pw_enable_in(pw_en), .pw_valid_in(pw_valid), .pw_word_in(pw_word), .pw_ready_out(pw_ready));
  ptrp_properties ptrp_properties_inst (.sys_clk_in(sys_clk), .sys_rst_in(sys_rst), .in_word(lnk.in_word),
    .in_ready(lnk.in_ready), .in_resume(lnk.in_resume), .in_active(lnk.in_active), .out_ready(lnk.out_ready),
    .out_resume(lnk.out_resume), .out_active(lnk.out_active));

  // Clock, watchdog and capture of one-cycle pulses
  always #12.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc_cnt++;
    if (rd_valid === 1'b1) begin nval++; lastw = rd_word; end
    if (bwe === 1'b1 && nb < 4) begin ba[nb] = baddr; bd[nb] = bdata; nb++; end
    if (bstart === 1'b1) nst++;
    if (cyc_cnt == 20000) begin errors++; complete_run(); end  // Whole run needs about 350
  end

  // ==========================================================================
  // Shared helpers
  task automatic cyc(input int n); repeat (n) @(posedge sys_clk); endtask : cyc
  task automatic chk(input string n, input logic [47:0] e, input logic [47:0] s);
    checked++;
    if (s !== e) begin errors++; $display("[ERR] %s expected %h seen %h", n, e, s); end
  endtask : chk
  // Pins pass a synchroniser, so pulses last several cycles
  task automatic feed_frame(input logic [7:0] f); frame <= f; feed <= 1; cyc(4); feed <= 0; cyc(6);
  endtask : feed_frame
  task automatic tim_pulse(); ptim <= 1; cyc(4); ptim <= 0; cyc(6); endtask : tim_pulse
  task automatic external_function_code(input logic [11:0] c); exf_code <= {c, 3'h0}; exf_req <= 1; cyc(1); exf_req <= 0; cyc(3);
  endtask : external_function_code
  task automatic sw(input bit a); m_assy <= a; m_char <= !a; cyc(4); m_assy <= 0; m_char <= 0; cyc(4);
  endtask : sw

  // ==========================================================================
  // Scenarios
  task automatic t_char();
    external_function_code(EXF_RD_NO_INT); rd_en <= 1; sw(0); nval = 0;
    chk("char mode", 48'h1, 48'(cmode));
    feed_frame(8'hA5);
    chk("char ready", 48'h1, 48'(nval));
    chk("char word", 48'hA5, lastw);
    $display("test char read done");
  endtask : t_char
  task automatic t_assy();
    logic [47:0] e;
    logic [5:0]  c;
    e = '0; rd_en <= 0; cyc(3); sw(1);
    chk("load clutch", 48'h1, 48'(clutch));
    chk("char flop", 48'h0, 48'(cmode));
    feed_frame(8'h40); rd_en <= 1; cyc(4); nval = 0;
    for (int i = 0; i < 8; i++) begin
      c = 6'(8'h05 + i * 7); e = {e[41:0], c};
      if (i == 7) chk("early ready", 48'h0, 48'(nval));
      feed_frame({1'b0, i == 0, c});
    end
    chk("assy ready", 48'h1, 48'(nval));
    chk("assy word", e, lastw);
    feed_frame(8'h01);
    chk("eot no level7", 48'h1, 48'(eot));
    chk("halt clutch", 48'h0, 48'(clutch));
    chk("no ready", 48'h1, 48'(nval));
    sw(0);
    chk("eot mode clear", 48'h0, 48'(eot));
    external_function_code(EXF_RD_SET_EOT);
    chk("eot by code", 48'h1, 48'(eot));
    rd_en <= 0; cyc(2);
    $display("test assembly read done");
  endtask : t_assy
  task automatic t_punch(input bit a, input logic [47:0] w);
    int k;
    external_function_code(a ? EXF_PU_ASSY : EXF_PU_CHAR);
    chk("motor on", 48'h1, 48'(motor));
    pw_en <= 1;
    for (k = 0; k < 50 && pw_ready !== 1'b1; k++) cyc(1);
    pw_word <= w; pw_valid <= 1; cyc(1); pw_valid <= 0; cyc(6);
    for (int i = 0; i < (a ? 8 : 1); i++) begin
      tim_pulse();
      chk("magnets", a ? 48'({2'b00, w[47 - 6 * i -: 6]}) : 48'(w[7:0]), 48'(mag));
    end
    chk("feed magnet", 48'h1, 48'(fmag));
    for (k = 0; k < 50 && pw_ready !== 1'b1; k++) cyc(1);
    chk("word resumed", 48'h1, 48'(pw_ready));
    $display("test punch done");
  endtask : t_punch
  task automatic t_boot();
    nb = 0; nst = 0; al_sw <= 1; cyc(4); al_sw <= 0; cyc(10);
    chk("boot addr0", 48'(BOOT_ADDR0), 48'(ba[0]));
    chk("boot data0", {BOOT_I0, BOOT_I1}, bd[0]);
    chk("boot addr1", 48'(BOOT_ADDR1), 48'(ba[1]));
    chk("boot data1", {BOOT_I2, 24'h000000}, bd[1]);
    bp <= BOOT_ADDR1; cyc(4); al_sw <= 1; cyc(4); al_sw <= 0; cyc(10);
    chk("boot starts", 48'h1, 48'(nst));
    oot <= 1; cyc(5);
    chk("out of tape", 48'h1, 48'(ootout));
    oot <= 0;
    $display("test auto load done");
  endtask : t_boot

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : complete_run

  // Main sequence
  initial begin
    cyc(10); sys_rst <= 0; cyc(4);
    t_char(); t_assy();
    t_punch(1, 48'hFEDCBA987654); t_punch(0, 48'h1234567890C3);
    // Timing edge with no word loaded punches nothing and stops feed
    tim_pulse();
    chk("magnets idle", 48'h0, 48'(mag));
    chk("feed idle", 48'h0, 48'(fmag));
    lead <= 1; cyc(5);
    chk("leader feed", 48'h1, 48'(fmag));
    lead <= 0; cyc(2);
    external_function_code(EXF_PU_MOTOFF);
    chk("motor off", 48'h0, 48'(motor));
    t_boot();
    complete_run();
  end
endmodule : paper_tape_reader_punch_control_bench
`default_nettype wire
